// >>> fcr_pkg.sv
package fcr_pkg;
   // ==========================================
   // bus and array widths
   localparam int APB_AW = 8;
   localparam int FLASH_AW = 16;
   // ==========================================
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SEC = 8'h04;
   // ==========================================
   // control/status field positions
   localparam int CTRL_READY = 0;
   localparam int CTRL_RWEN = 1;
   localparam int CTRL_B0EN = 2;
   localparam int CTRL_STOP = 3;
   localparam int CTRL_PERR = 6;
   localparam int CTRL_EERR = 7;
   localparam int SEC_B0LOCK = 5;
   localparam logic RST_B0LOCK = 1'h0;
   // ==========================================
   // status byte seen on flash reads
   localparam int ST_READY = 7;
   localparam int ST_EERR = 5;
   localparam int ST_PERR = 4;
   // ==========================================
   // command bytes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_OK = 8'hd0;
   // ==========================================
   // default address map
   localparam logic [FLASH_AW-1:0] USER_LO = 16'h4000;
   localparam logic [FLASH_AW-1:0] USER_HI = 16'hffff;
   localparam logic [FLASH_AW-1:0] BLK0_LO = 16'hc000;
   localparam logic [FLASH_AW-1:0] BLK0_HI = 16'hffff;
   // ==========================================
   // modes and carriers
   typedef enum logic [2:0] {
      MODE_READ_ARRAY, MODE_READ_STATUS, MODE_PROG_DATA,
      MODE_ERASE_OK, MODE_PROGRAMMING, MODE_ERASING
   } fcr_mode_type;
   typedef struct packed {
      logic req;
      logic we;
      logic [FLASH_AW-1:0] addr;
      logic [7:0] wdata;
   } fcr_flash_req_type;
   typedef struct packed {
      logic progStart;
      logic eraseStart;
      logic init;
      logic [FLASH_AW-1:0] addr;
      logic [7:0] data;
   } fcr_macro_cmd_type;
   typedef struct packed {
      logic done;
      logic fail;
      logic [7:0] rdata;
   } fcr_macro_rsp_type;
endpackage

// >>> fcr_addr_class.sv
`timescale 1ns/10ps
module fcr_addr_class #(
   parameter logic [15:0] USER_LO = fcr_pkg::USER_LO,
   parameter logic [15:0] USER_HI = fcr_pkg::USER_HI,
   parameter logic [15:0] BLK0_LO = fcr_pkg::BLK0_LO,
   parameter logic [15:0] BLK0_HI = fcr_pkg::BLK0_HI
) (
   // address to classify
   input wire logic [15:0] addr,
   // result
   output logic inUser,
   output logic inBlock0
);
   // ==========================================
   // map checks
   if (USER_LO > USER_HI || BLK0_LO > BLK0_HI || BLK0_LO < USER_LO || BLK0_HI > USER_HI) begin : g_bad
      $error("block 0 must lie inside the user area");
   end
   always_comb begin
      inUser = (addr >= USER_LO) && (addr <= USER_HI);
      inBlock0 = (addr >= BLK0_LO) && (addr <= BLK0_HI);
   end
endmodule // fcr_addr_class

// >>> fcr_apb_decode.sv
`timescale 1ns/10ps
module fcr_apb_decode (
   // byte address
   input wire logic [7:0] paddr,
   // selects
   output logic selCtrl,
   output logic selSec,
   output logic hit
);
   // ==========================================
   // word decode
   always_comb begin
      selCtrl = (paddr == fcr_pkg::OFS_CTRL);
      selSec = (paddr == fcr_pkg::OFS_SEC);
      hit = selCtrl || selSec;
   end
endmodule // fcr_apb_decode

// >>> fcr_rewrite_ctrl.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - after program or erase, flash reads return the status byte.
// - after read-status, flash reads keep returning the status byte.
// - ready and error flags visible in control register and in status byte.
// - ready reads 0 while programming or erasing, 1 otherwise.
// - commands are accepted only while rewrite mode enable is 1.
// - clearing rewrite enable also clears block 0 enable.
// - block 0 enable at 0 rejects program and erase on block 0.
// - with block 0 enable at 1, the second lock decides block 0.
// - effective stop blocks flash access, reinitialises control, cuts current.
// - stop acts only with rewrite enable 1; otherwise it is merely stored.
// - low-power entry with rewrite disabled switches flash power off automatically.
// - program error flag is read-only, set on auto-program failure.
// - erase error flag is read-only, set on auto-erase failure.
// - clear-status command returns both error flags to 0.
// - both flags 1 means sequence error, one alone its error, none success.
// - sequence error on bad erase confirm byte, locked block or unmapped address.
// - block 0 accepts rewriting only with enable 1 and second lock 0.
module fcr_rewrite_ctrl #(
   parameter logic [15:0] USER_LO = fcr_pkg::USER_LO,
   parameter logic [15:0] USER_HI = fcr_pkg::USER_HI,
   parameter logic [15:0] BLK0_LO = fcr_pkg::BLK0_LO,
   parameter logic [15:0] BLK0_HI = fcr_pkg::BLK0_HI
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu flash port
   input wire fcr_pkg::fcr_flash_req_type flashReq,
   output logic flashGrant,
   output logic flashRdValid,
   output logic [7:0] flashRdData,
   // flash macro
   output fcr_pkg::fcr_macro_cmd_type macroCmd,
   input wire fcr_pkg::fcr_macro_rsp_type macroRsp,
   // power
   input wire logic lowPowerEntry,
   output logic flashPowerOn
);
   // ==========================================
   // state
   typedef struct packed {
      fcr_pkg::fcr_mode_type mode;
      logic rwEn;
      logic b0En;
      logic stop;
      logic progErr;
      logic eraseErr;
      logic b0Lock;
      logic powerOn;
      logic [31:0] prdata;
      fcr_pkg::fcr_macro_cmd_type cmd;
      logic rdValid;
      logic [7:0] rdData;
   } fcr_regs_type;

   fcr_regs_type st;
   fcr_regs_type next_st;
   logic selCtrl;
   logic selSec;
   logic hit;
   logic inUser;
   logic inBlock0;
   logic busy;
   logic stopEff;
   logic take;
   logic addrOk;
   logic [7:0] ctrlByte;
   logic [7:0] statusByte;

   // ==========================================
   // helpers
   fcr_apb_decode u_dec (
      .paddr(paddr),
      .selCtrl(selCtrl),
      .selSec(selSec),
      .hit(hit)
   );

   fcr_addr_class #(
      .USER_LO(USER_LO),
      .USER_HI(USER_HI),
      .BLK0_LO(BLK0_LO),
      .BLK0_HI(BLK0_HI)
   ) u_cls (
      .addr(flashReq.addr),
      .inUser(inUser),
      .inBlock0(inBlock0)
   );

   // ==========================================
   // derived terms
   always_comb begin
      busy = (st.mode == fcr_pkg::MODE_PROGRAMMING) || (st.mode == fcr_pkg::MODE_ERASING);
      stopEff = st.stop && st.rwEn;
      // refusing beats stalling: a stopped array has nothing valid to return
      take = flashReq.req && flashGrant;
      // block 0 needs both keys; other blocks only need to be mapped
      addrOk = inUser && (!inBlock0 || (st.b0En && !st.b0Lock));
      ctrlByte = 8'h00;
      ctrlByte[fcr_pkg::CTRL_READY] = !busy;
      ctrlByte[fcr_pkg::CTRL_RWEN] = st.rwEn;
      ctrlByte[fcr_pkg::CTRL_B0EN] = st.b0En;
      ctrlByte[fcr_pkg::CTRL_STOP] = st.stop;
      ctrlByte[fcr_pkg::CTRL_PERR] = st.progErr;
      ctrlByte[fcr_pkg::CTRL_EERR] = st.eraseErr;
      statusByte = 8'h00;
      statusByte[fcr_pkg::ST_READY] = !busy;
      statusByte[fcr_pkg::ST_EERR] = st.eraseErr;
      statusByte[fcr_pkg::ST_PERR] = st.progErr;
   end

   // ==========================================
   // next state
   always_comb begin
      next_st = st;
      next_st.cmd.progStart = 1'h0;
      next_st.cmd.eraseStart = 1'h0;
      next_st.rdValid = 1'h0;
      // apb read data latched in setup so access phase needs no wait
      if (psel && !penable) begin
         if (selCtrl) begin
            next_st.prdata = {24'h000000, ctrlByte};
         end else if (selSec) begin
            next_st.prdata = 32'h00000000;
            next_st.prdata[fcr_pkg::SEC_B0LOCK] = st.b0Lock;
         end else begin
            next_st.prdata = 32'h00000000;
         end
      end
      // apb writes; ready and error bits are not writable
      if (psel && penable && pwrite && selCtrl) begin
         next_st.rwEn = pwdata[fcr_pkg::CTRL_RWEN];
         next_st.stop = pwdata[fcr_pkg::CTRL_STOP];
         next_st.b0En = pwdata[fcr_pkg::CTRL_B0EN] && pwdata[fcr_pkg::CTRL_RWEN];
      end
      if (psel && penable && pwrite && selSec) begin
         next_st.b0Lock = pwdata[fcr_pkg::SEC_B0LOCK];
      end
      // auto operation completion
      if (st.mode == fcr_pkg::MODE_PROGRAMMING && macroRsp.done) begin
         next_st.mode = fcr_pkg::MODE_READ_STATUS;
         if (macroRsp.fail) begin
            next_st.progErr = 1'h1;
         end
      end
      if (st.mode == fcr_pkg::MODE_ERASING && macroRsp.done) begin
         next_st.mode = fcr_pkg::MODE_READ_STATUS;
         if (macroRsp.fail) begin
            next_st.eraseErr = 1'h1;
         end
      end
      // cpu flash reads
      if (take && !flashReq.we) begin
         next_st.rdValid = 1'h1;
         if (st.mode == fcr_pkg::MODE_READ_ARRAY) begin
            next_st.rdData = macroRsp.rdata;
         end else begin
            next_st.rdData = statusByte;
         end
      end
      // command writes, ignored while busy or rewrite disabled
      if (take && flashReq.we && st.rwEn && !busy) begin
         case (st.mode)
            fcr_pkg::MODE_PROG_DATA: begin
               if (addrOk) begin
                  next_st.cmd.progStart = 1'h1;
                  next_st.cmd.addr = flashReq.addr;
                  next_st.cmd.data = flashReq.wdata;
                  next_st.mode = fcr_pkg::MODE_PROGRAMMING;
               end else begin
                  next_st.progErr = 1'h1;
                  next_st.eraseErr = 1'h1;
                  next_st.mode = fcr_pkg::MODE_READ_STATUS;
               end
            end
            fcr_pkg::MODE_ERASE_OK: begin
               if (flashReq.wdata == fcr_pkg::CMD_READ_ARRAY) begin
                  next_st.mode = fcr_pkg::MODE_READ_ARRAY;
               end else if (flashReq.wdata == fcr_pkg::CMD_ERASE_OK && addrOk) begin
                  next_st.cmd.eraseStart = 1'h1;
                  next_st.cmd.addr = flashReq.addr;
                  next_st.mode = fcr_pkg::MODE_ERASING;
               end else begin
                  next_st.progErr = 1'h1;
                  next_st.eraseErr = 1'h1;
                  next_st.mode = fcr_pkg::MODE_READ_STATUS;
               end
            end
            default: begin
               case (flashReq.wdata)
                  fcr_pkg::CMD_READ_ARRAY: begin
                     next_st.mode = fcr_pkg::MODE_READ_ARRAY;
                  end
                  fcr_pkg::CMD_READ_STATUS: begin
                     next_st.mode = fcr_pkg::MODE_READ_STATUS;
                  end
                  fcr_pkg::CMD_CLEAR_STATUS: begin
                     next_st.progErr = 1'h0;
                     next_st.eraseErr = 1'h0;
                  end
                  fcr_pkg::CMD_PROGRAM: begin
                     next_st.mode = fcr_pkg::MODE_PROG_DATA;
                  end
                  fcr_pkg::CMD_ERASE: begin
                     next_st.mode = fcr_pkg::MODE_ERASE_OK;
                  end
                  default: begin
                     next_st.progErr = 1'h1;
                     next_st.eraseErr = 1'h1;
                     next_st.mode = fcr_pkg::MODE_READ_STATUS;
                  end
               endcase
            end
         endcase
      end
      // stop reinitialises; a stuck busy state is abandoned here
      if (stopEff) begin
         next_st.mode = fcr_pkg::MODE_READ_ARRAY;
         next_st.cmd.progStart = 1'h0;
         next_st.cmd.eraseStart = 1'h0;
      end
      next_st.cmd.init = next_st.stop && next_st.rwEn;
      // flash supply off when stopped, or on low-power entry outside rewrite mode
      next_st.powerOn = !(next_st.cmd.init || (lowPowerEntry && !next_st.rwEn));
   end

   // ==========================================
   // registers
   always_ff @(posedge clk) begin
      if (srst) begin
         st.mode <= fcr_pkg::MODE_READ_ARRAY;
         st.rwEn <= 1'h0;
         st.b0En <= 1'h0;
         st.stop <= 1'h0;
         st.progErr <= 1'h0;
         st.eraseErr <= 1'h0;
         st.b0Lock <= fcr_pkg::RST_B0LOCK;
         st.powerOn <= 1'h1;
         st.prdata <= 32'h00000000;
         st.cmd <= '0;
         st.rdValid <= 1'h0;
         st.rdData <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // outputs
   always_comb begin
      prdata = st.prdata;
      pready = 1'h1;
      pslverr = psel && penable && !hit;
      flashGrant = !stopEff && st.powerOn;
      flashRdValid = st.rdValid;
      flashRdData = st.rdData;
      macroCmd = st.cmd;
      flashPowerOn = st.powerOn;
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   chk_ready_busy: assert property (macroCmd.progStart || macroCmd.eraseStart
      |-> !ctrlByte[fcr_pkg::CTRL_READY] && !statusByte[fcr_pkg::ST_READY])
      else $error("ready flag high while an operation runs");

   chk_status_after_op: assert property ((st.mode == fcr_pkg::MODE_PROGRAMMING) && macroRsp.done && !stopEff
      |=> st.mode == fcr_pkg::MODE_READ_STATUS)
      else $error("no status mode after program");

   chk_status_read: assert property (take && !flashReq.we && st.mode == fcr_pkg::MODE_READ_STATUS
      |=> flashRdValid && flashRdData == $past(statusByte))
      else $error("status read returned wrong byte");

   chk_cmd_gate: assert property ($rose(macroCmd.progStart) || $rose(macroCmd.eraseStart)
      |-> $past(st.rwEn))
      else $error("operation started with rewrite disabled");

   chk_b0_clear: assert property ($fell(st.rwEn) |-> !st.b0En)
      else $error("block 0 enable survived rewrite disable");

   chk_b0_guard: assert property ((macroCmd.progStart || macroCmd.eraseStart)
      && macroCmd.addr >= BLK0_LO && macroCmd.addr <= BLK0_HI |-> $past(st.b0En) && !$past(st.b0Lock))
      else $error("block 0 rewritten while locked");

   chk_stop_effect: assert property (stopEff |-> (macroCmd.init && !flashGrant)
      ##1 (st.mode == fcr_pkg::MODE_READ_ARRAY))
      else $error("stop did not reinitialise");

   // supply and init both come from the same next-state stop term
   chk_stop_power: assert property (stopEff |-> !flashPowerOn)
      else $error("flash supply on while stopped");

   chk_stop_stored: assert property (st.stop && !st.rwEn && !lowPowerEntry ##1 st.stop && !st.rwEn
      |-> flashPowerOn && !macroCmd.init)
      else $error("stop acted outside rewrite mode");

   chk_lp_power: assert property (lowPowerEntry && !st.rwEn && !(psel && penable && pwrite)
      |=> !flashPowerOn)
      else $error("flash power stayed on in low power");

   chk_prog_err: assert property (st.mode == fcr_pkg::MODE_PROGRAMMING && macroRsp.done
      && macroRsp.fail && !stopEff |=> st.progErr && ctrlByte[fcr_pkg::CTRL_PERR])
      else $error("program failure not flagged");

   chk_erase_err: assert property (st.mode == fcr_pkg::MODE_ERASING && macroRsp.done
      && macroRsp.fail && !stopEff |=> st.eraseErr && !$changed(st.progErr))
      else $error("erase failure not flagged");

   chk_clear_status: assert property (take && flashReq.we && st.rwEn && !busy && !stopEff
      && flashReq.wdata == fcr_pkg::CMD_CLEAR_STATUS && (st.mode inside
      {fcr_pkg::MODE_READ_ARRAY, fcr_pkg::MODE_READ_STATUS}) |=> !st.progErr && !st.eraseErr)
      else $error("clear status left flags set");

   chk_seq_err: assert property (take && flashReq.we && st.rwEn && !stopEff
      && st.mode == fcr_pkg::MODE_ERASE_OK
      && flashReq.wdata != fcr_pkg::CMD_ERASE_OK && flashReq.wdata != fcr_pkg::CMD_READ_ARRAY
      |=> st.progErr && st.eraseErr)
      else $error("bad erase confirm not flagged");
endmodule // fcr_rewrite_ctrl

// >>> fcr_tb.sv
`timescale 1ns/10ps
module testbench;
   // ==========================================
   // clock, reset and design ports
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, flashGrant, flashRdValid, flashPowerOn;
   logic [7:0] flashRdData;
   fcr_pkg::fcr_flash_req_type flashReq = '0;
   fcr_pkg::fcr_macro_cmd_type macroCmd;
   fcr_pkg::fcr_macro_rsp_type macroRsp;
   logic rspDone = 1'h0, rspFail = 1'h0, lowPowerEntry = 1'h0;
   int errors = 0, n_checks = 0, starts = 0, expStarts = 0;
   localparam logic [31:0] FULL = 32'hffffffff;
   localparam logic [7:0] STM = 8'hb0;
   // array model: byte depends on address so a stale byte shows
   assign macroRsp = '{done: rspDone, fail: rspFail, rdata: flashReq.addr[7:0] ^ 8'ha5};
   always #2 clk = ~clk;
   always @(posedge clk) if (macroCmd.progStart === 1'b1 || macroCmd.eraseStart === 1'b1) starts++;
   fcr_rewrite_ctrl i_fcr_rewrite_ctrl (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flashReq(flashReq), .flashGrant(flashGrant), .flashRdValid(flashRdValid),
      .flashRdData(flashRdData), .macroCmd(macroCmd), .macroRsp(macroRsp),
      .lowPowerEntry(lowPowerEntry), .flashPowerOn(flashPowerOn));
   // ==========================================
   // helpers
   function automatic logic [31:0] cx(logic rdy, logic rw, logic b0, logic st, logic pe, logic ee);
      logic [31:0] r;
      r = 32'h0;
      r[fcr_pkg::CTRL_READY] = rdy;
      r[fcr_pkg::CTRL_RWEN] = rw;
      r[fcr_pkg::CTRL_B0EN] = b0;
      r[fcr_pkg::CTRL_STOP] = st;
      r[fcr_pkg::CTRL_PERR] = pe;
      r[fcr_pkg::CTRL_EERR] = ee;
      return r;
   endfunction
   function automatic logic [7:0] sx(logic rdy, logic ee, logic pe);
      logic [7:0] r;
      r = 8'h00;
      r[fcr_pkg::ST_READY] = rdy;
      r[fcr_pkg::ST_EERR] = ee;
      r[fcr_pkg::ST_PERR] = pe;
      return r;
   endfunction
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // apb master: hold until pready at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(name, exp & m, r & m);
   endtask
   // ==========================================
   // cpu flash port: request held until granted at an edge
   task automatic fop(input logic we, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rdv);
      int k;
      @(posedge clk);
      flashReq <= '{req: 1'b1, we: we, addr: a, wdata: d};
      do begin
         @(posedge clk);
      end while (flashGrant !== 1'b1);
      flashReq.req <= 1'b0;
      rdv = 8'h00;
      if (!we) begin
         k = 0;
         #1;
         while (flashRdValid !== 1'b1 && k < 3) begin
            @(posedge clk);
            #1;
            k++;
         end
         check("flashRdValid", 32'h1, {31'h0, flashRdValid});
         rdv = flashRdData;
      end
   endtask
   task automatic fw(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] x;
      fop(1'b1, a, d, x);
   endtask
   task automatic fr(input string name, input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m);
      logic [7:0] x;
      fop(1'b0, a, 8'h00, x);
      check(name, {24'h0, exp & m}, {24'h0, x & m});
   endtask
   // macro side: wait for the start pulse, look while busy, then finish
   task automatic macroRun(input logic er, input logic [15:0] a, input logic [7:0] d, input logic f);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((er ? macroCmd.eraseStart : macroCmd.progStart) !== 1'b1 && k < 20);
      check("macroStart", 32'h1, {31'h0, er ? macroCmd.eraseStart : macroCmd.progStart});
      expStarts++;
      check("macroAddr", {16'h0, a}, {16'h0, macroCmd.addr});
      if (!er) check("macroData", {24'h0, d}, {24'h0, macroCmd.data});
      rd("busyReady", fcr_pkg::OFS_CTRL, 32'h0, 32'h1);
      fr("busyStatus", 16'h4000, 8'h00, 8'h80);
      @(posedge clk);
      rspDone <= 1'b1;
      rspFail <= f;
      @(posedge clk);
      rspDone <= 1'b0;
      rspFail <= 1'b0;
   endtask
   // ==========================================
   // tests; commands aim at the user area, except one program at unmapped 1000h
   initial begin : main
      logic [31:0] r;
      logic e;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rd("ctrlReset", fcr_pkg::OFS_CTRL, cx(1, 0, 0, 0, 0, 0), FULL);
      rd("secReset", fcr_pkg::OFS_SEC, 32'h0, FULL);
      apb(1'b1, 8'h08, 32'hff, r, e);
      check("unmappedErr", 32'h1, {31'h0, e});
      apb(1'b0, 8'h08, 32'h0, r, e);
      check("unmappedRead", 32'h0, r);
      // commands while rewrite is disabled are ignored
      fw(16'h4000, fcr_pkg::CMD_PROGRAM);
      fw(16'h4000, 8'h3c);
      repeat (5) @(posedge clk);
      check("noStart", expStarts, starts);
      fr("arrayRead", 16'h4010, 8'h10 ^ 8'ha5, 8'hff);
      wr(fcr_pkg::OFS_CTRL, 32'h0);
      wr(fcr_pkg::OFS_CTRL, 32'hc0 | cx(0, 1, 0, 0, 0, 0));
      rd("roBits", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 0, 0), FULL);
      // program ok, then program fail
      fw(16'h4000, fcr_pkg::CMD_PROGRAM);
      fw(16'h4000, 8'h3c);
      macroRun(1'b0, 16'h4000, 8'h3c, 1'b0);
      rd("progOk", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 0, 0), FULL);
      fr("statusAfterProg", 16'h4000, sx(1, 0, 0), STM);
      fw(16'h4001, fcr_pkg::CMD_PROGRAM);
      fw(16'h4001, 8'h5a);
      macroRun(1'b0, 16'h4001, 8'h5a, 1'b1);
      rd("progErr", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 1, 0), FULL);
      fr("progErrStatus", 16'h4001, sx(1, 0, 1), STM);
      fw(16'h4000, fcr_pkg::CMD_CLEAR_STATUS);
      rd("cleared", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 0, 0), FULL);
      fw(16'h4000, fcr_pkg::CMD_READ_STATUS);
      fr("readStatus1", 16'h4002, sx(1, 0, 0), STM);
      fr("readStatus2", 16'h4003, sx(1, 0, 0), STM);
      // erase fail
      fw(16'h4000, fcr_pkg::CMD_ERASE);
      fw(16'h4000, fcr_pkg::CMD_ERASE_OK);
      macroRun(1'b1, 16'h4000, 8'h00, 1'b1);
      rd("eraseErr", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 0, 1), FULL);
      fr("eraseErrStatus", 16'h4000, sx(1, 1, 0), STM);
      // block 0 locked by its enable bit
      fw(16'h4000, fcr_pkg::CMD_CLEAR_STATUS);
      fw(16'hc000, fcr_pkg::CMD_PROGRAM);
      fw(16'hc000, 8'h11);
      repeat (5) @(posedge clk);
      check("blk0NoStart", expStarts, starts);
      rd("blk0SeqErr", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 1, 1), FULL);
      fr("seqErrStatus", 16'h4000, sx(1, 1, 1), STM);
      // bad erase confirm byte, unmapped program, unknown command, then ffh confirm returns to array reads
      fw(16'h4000, fcr_pkg::CMD_CLEAR_STATUS);
      fw(16'h4000, fcr_pkg::CMD_ERASE);
      fw(16'h4000, 8'h12);
      rd("badConfirm", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 1, 1), FULL);
      fw(16'h4000, fcr_pkg::CMD_CLEAR_STATUS);
      fw(16'h1000, fcr_pkg::CMD_PROGRAM);
      fw(16'h1000, 8'h33);
      rd("unmappedProg", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 1, 1), FULL);
      fw(16'h4000, fcr_pkg::CMD_CLEAR_STATUS);
      fw(16'h4000, 8'h3c);
      rd("unknownCmd", fcr_pkg::OFS_CTRL, cx(1, 1, 0, 0, 1, 1), FULL);
      fw(16'h4000, fcr_pkg::CMD_CLEAR_STATUS);
      fw(16'h4000, fcr_pkg::CMD_ERASE);
      fw(16'h4000, fcr_pkg::CMD_READ_ARRAY);
      fr("ffConfirm", 16'h4020, 8'h20 ^ 8'ha5, 8'hff);
      check("ffNoStart", expStarts, starts);
      // block 0 with enable set: second lock decides
      wr(fcr_pkg::OFS_CTRL, cx(0, 1, 0, 0, 0, 0));
      wr(fcr_pkg::OFS_CTRL, cx(0, 1, 1, 0, 0, 0));
      wr(fcr_pkg::OFS_SEC, 32'h1 << fcr_pkg::SEC_B0LOCK);
      rd("secLock", fcr_pkg::OFS_SEC, 32'h1 << fcr_pkg::SEC_B0LOCK, FULL);
      fw(16'hc000, fcr_pkg::CMD_PROGRAM);
      fw(16'hc000, 8'h22);
      rd("lockErr", fcr_pkg::OFS_CTRL, cx(1, 1, 1, 0, 1, 1), FULL);
      fw(16'h4000, fcr_pkg::CMD_CLEAR_STATUS);
      wr(fcr_pkg::OFS_SEC, 32'h0);
      fw(16'hc000, fcr_pkg::CMD_PROGRAM);
      fw(16'hc000, 8'h22);
      macroRun(1'b0, 16'hc000, 8'h22, 1'b0);
      rd("blk0Ok", fcr_pkg::OFS_CTRL, cx(1, 1, 1, 0, 0, 0), FULL);
      check("startCount", expStarts, starts);
      // leaving rewrite mode clears block 0 enable
      fw(16'h4000, fcr_pkg::CMD_READ_ARRAY);
      wr(fcr_pkg::OFS_CTRL, cx(0, 0, 1, 0, 0, 0));
      rd("b0Forced", fcr_pkg::OFS_CTRL, cx(1, 0, 0, 0, 0, 0), FULL);
      // stop only stored while rewrite disabled
      wr(fcr_pkg::OFS_CTRL, cx(0, 0, 0, 1, 0, 0));
      rd("stopStored", fcr_pkg::OFS_CTRL, cx(1, 0, 0, 1, 0, 0), FULL);
      repeat (3) @(posedge clk);
      check("stopIdle", 32'h5, {29'h0, flashGrant, macroCmd.init, flashPowerOn});
      // effective stop: init held, reads refused, power cut
      wr(fcr_pkg::OFS_CTRL, cx(0, 1, 0, 0, 0, 0));
      wr(fcr_pkg::OFS_CTRL, cx(0, 1, 0, 1, 0, 0));
      repeat (3) @(posedge clk);
      check("stopOn", 32'h2, {29'h0, flashGrant, macroCmd.init, flashPowerOn});
      wr(fcr_pkg::OFS_CTRL, cx(0, 1, 0, 0, 0, 0));
      repeat (3) @(posedge clk);
      check("stopOff", 32'h5, {29'h0, flashGrant, macroCmd.init, flashPowerOn});
      fr("afterStop", 16'h4030, 8'h30 ^ 8'ha5, 8'hff);
      // low power entry with rewrite disabled
      wr(fcr_pkg::OFS_CTRL, 32'h0);
      lowPowerEntry <= 1'b1;
      repeat (3) @(posedge clk);
      check("lpOff", 32'h0, {30'h0, flashGrant, flashPowerOn});
      lowPowerEntry <= 1'b0;
      repeat (3) @(posedge clk);
      check("lpOn", 32'h3, {30'h0, flashGrant, flashPowerOn});
      conclude();
   end
   // ==========================================
   // watchdog: the tests need a few hundred cycles
   initial begin : watchdog
      #40000;
      errors++;
      conclude();
   end
endmodule // testbench
